// [lsd_pkg.sv]
// lsd_pkg: operation codes, operand kinds, encoding lengths and state counts
// for the logical and shift datapath; used by both design files
package lsd_pkg;
	typedef enum logic [3:0] {
		LSD_AND_OP = 4'h0,
		LSD_OR_OP = 4'h1,
		LSD_XOR_OP = 4'h2,
		LSD_CLEAR_OP = 4'h3,
		LSD_INVERT_OP = 4'h4,
		LSD_ROTATE_LEFT_OP = 4'h5,
		LSD_ROTATE_RIGHT_OP = 4'h6,
		LSD_ROTATE_LEFT_CARRY_OP = 4'h7,
		LSD_ROTATE_RIGHT_CARRY_OP = 4'h8,
		LSD_SHIFT_LEFT_LOGICAL_OP = 4'h9,
		LSD_SHIFT_RIGHT_ARITH_OP = 4'hA,
		LSD_SHIFT_RIGHT_LOGICAL_OP = 4'hB,
		LSD_SWAP_OP = 4'hC
	} lsd_op_e;

	// operand form of the instruction
	typedef enum logic [3:0] {
		LSD_F_ACC_REG = 4'h0,
		LSD_F_ACC_DIR = 4'h1,
		LSD_F_ACC_IND = 4'h2,
		LSD_F_ACC_IMM = 4'h3,
		LSD_F_DIR_ACC = 4'h4,
		LSD_F_DIR_IMM = 4'h5,
		LSD_F_BYTE_BYTE = 4'h6,
		LSD_F_WORD_WORD = 4'h7,
		LSD_F_BYTE_IMM = 4'h8,
		LSD_F_WORD_IMM = 4'h9,
		LSD_F_BYTE_DIR = 4'hA,
		LSD_F_WORD_DIR = 4'hB,
		LSD_F_BYTE_LDIR = 4'hC,
		LSD_F_WORD_LDIR = 4'hD,
		LSD_F_BYTE_WPTR = 4'hE,
		LSD_F_BYTE_DPTR = 4'hF
	} lsd_form_e;

	// where the direct or memory operand lives
	typedef enum logic [1:0] {
		LSD_T_RAM = 2'h0,
		LSD_T_PORT = 2'h1,
		LSD_T_SFR = 2'h2,
		LSD_T_EXT = 2'h3
	} lsd_target_e;

	localparam logic [3:0] LSD_PORT_READ_ADD = 4'h1;
	localparam logic [3:0] LSD_SFR_READ_ADD = 4'h2;
	localparam logic [3:0] LSD_PORT_WRITE_ADD = 4'h2;
	localparam logic [3:0] LSD_SFR_WRITE_ADD = 4'h3;
	localparam logic [3:0] LSD_EXT_FIXED_ADD = 4'h2;
	localparam logic [3:0] LSD_ONE_STATE = 4'h1;
	localparam logic [3:0] LSD_SWAP_STATES = 4'h2;
	localparam logic [3:0] LSD_SHIFT_BIN_STATES = 4'h2;
	localparam logic [3:0] LSD_SHIFT_SRC_STATES = 4'h1;
	localparam logic [2:0] LSD_SHIFT_BIN_BYTES = 3'h3;
	localparam logic [2:0] LSD_SHIFT_SRC_BYTES = 3'h2;
	localparam logic [2:0] LSD_ONE_BYTE = 3'h1;
	localparam logic [15:0] LSD_ZERO16 = 16'h0000;
endpackage

// [lsd_timing_if.sv]
// lsd_timing_if: ties the timing table to the sequencer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface lsd_timing_if;
	logic [3:0] form;
	logic is_logic;
	logic is_shift;
	logic is_swap;
	logic source_mode;
	logic [1:0] target;
	logic [3:0] wait_states;
	logic [2:0] bytes;
	logic [7:0] states;
	modport table_end (input form, is_logic, is_shift, is_swap, source_mode,
		target, wait_states, output bytes, states);
	modport seq_end (output form, is_logic, is_shift, is_swap, source_mode,
		target, wait_states, input bytes, states);
endinterface

// [lsd_timing.sv]
// lsd_timing: instruction length and state count for one operation
// assumes inputs are stable while the sequencer holds them
`timescale 1ns/100ps
module lsd_timing (
	lsd_timing_if.table_end t
);
	logic [3:0] base;
	logic [3:0] extra;
	logic [2:0] len;
	logic [7:0] ext_n2;

	always_comb begin
		base = lsd_pkg::LSD_ONE_STATE;
		len = lsd_pkg::LSD_ONE_BYTE;
		extra = 4'h0;
		ext_n2 = 8'(t.wait_states) + 8'(lsd_pkg::LSD_EXT_FIXED_ADD);
		if (t.is_swap) begin
			base = lsd_pkg::LSD_SWAP_STATES;
		end else if (t.is_shift) begin
			base = t.source_mode ? lsd_pkg::LSD_SHIFT_SRC_STATES :
				lsd_pkg::LSD_SHIFT_BIN_STATES;
			len = t.source_mode ? lsd_pkg::LSD_SHIFT_SRC_BYTES :
				lsd_pkg::LSD_SHIFT_BIN_BYTES;
		end else if (t.is_logic) begin
			case (t.form)
				lsd_pkg::LSD_F_ACC_REG: begin
					base = t.source_mode ? 4'h2 : 4'h1;
					len = t.source_mode ? 3'h2 : 3'h1;
				end
				lsd_pkg::LSD_F_ACC_DIR: begin
					base = 4'h1;
					len = 3'h2;
				end
				lsd_pkg::LSD_F_ACC_IND: begin
					base = t.source_mode ? 4'h3 : 4'h2;
					len = t.source_mode ? 3'h2 : 3'h1;
				end
				lsd_pkg::LSD_F_ACC_IMM: begin
					base = 4'h1;
					len = 3'h2;
				end
				lsd_pkg::LSD_F_DIR_ACC: begin
					base = 4'h2;
					len = 3'h2;
				end
				lsd_pkg::LSD_F_DIR_IMM: begin
					base = 4'h3;
					len = 3'h3;
				end
				lsd_pkg::LSD_F_BYTE_BYTE: begin
					base = t.source_mode ? 4'h1 : 4'h2;
					len = t.source_mode ? 3'h2 : 3'h3;
				end
				lsd_pkg::LSD_F_WORD_WORD: begin
					base = t.source_mode ? 4'h2 : 4'h3;
					len = t.source_mode ? 3'h2 : 3'h3;
				end
				lsd_pkg::LSD_F_BYTE_IMM: begin
					base = t.source_mode ? 4'h2 : 4'h3;
					len = t.source_mode ? 3'h3 : 3'h4;
				end
				lsd_pkg::LSD_F_WORD_IMM: begin
					base = t.source_mode ? 4'h3 : 4'h4;
					len = t.source_mode ? 3'h4 : 3'h5;
				end
				lsd_pkg::LSD_F_BYTE_DIR: begin
					base = t.source_mode ? 4'h2 : 4'h3;
					len = t.source_mode ? 3'h3 : 3'h4;
				end
				lsd_pkg::LSD_F_WORD_DIR: begin
					base = t.source_mode ? 4'h3 : 4'h4;
					len = t.source_mode ? 3'h3 : 3'h4;
				end
				lsd_pkg::LSD_F_BYTE_LDIR: begin
					base = t.source_mode ? 4'h2 : 4'h3;
					len = t.source_mode ? 3'h4 : 3'h5;
				end
				lsd_pkg::LSD_F_WORD_LDIR: begin
					base = t.source_mode ? 4'h3 : 4'h4;
					len = t.source_mode ? 3'h4 : 3'h5;
				end
				lsd_pkg::LSD_F_BYTE_WPTR: begin
					base = t.source_mode ? 4'h2 : 4'h3;
					len = t.source_mode ? 3'h3 : 3'h4;
				end
				lsd_pkg::LSD_F_BYTE_DPTR: begin
					base = t.source_mode ? 4'h3 : 4'h4;
					len = t.source_mode ? 3'h3 : 3'h4;
				end
				default: begin
					base = lsd_pkg::LSD_ONE_STATE;
				end
			endcase
			// port and sfr penalties only where an sfr can be addressed
			if (t.form == lsd_pkg::LSD_F_ACC_DIR ||
				t.form == lsd_pkg::LSD_F_BYTE_DIR) begin
				if (t.target == lsd_pkg::LSD_T_PORT)
					extra = lsd_pkg::LSD_PORT_READ_ADD;
				else if (t.target == lsd_pkg::LSD_T_SFR)
					extra = lsd_pkg::LSD_SFR_READ_ADD;
			end
			if (t.form == lsd_pkg::LSD_F_DIR_ACC ||
				t.form == lsd_pkg::LSD_F_DIR_IMM) begin
				if (t.target == lsd_pkg::LSD_T_PORT)
					extra = lsd_pkg::LSD_PORT_WRITE_ADD;
				else if (t.target == lsd_pkg::LSD_T_SFR)
					extra = lsd_pkg::LSD_SFR_WRITE_ADD;
			end
		end
	end

	always_comb begin
		t.bytes = len;
		t.states = 8'(base) + 8'(extra);
		if (t.is_logic && !t.is_shift && !t.is_swap &&
			t.target == lsd_pkg::LSD_T_EXT) begin
			if (t.form == lsd_pkg::LSD_F_BYTE_LDIR ||
				t.form == lsd_pkg::LSD_F_BYTE_WPTR ||
				t.form == lsd_pkg::LSD_F_BYTE_DPTR)
				t.states = 8'(base) + ext_n2;
			else if (t.form == lsd_pkg::LSD_F_WORD_LDIR)
				t.states = 8'(base) + 8'(ext_n2 << 1);
		end
	end
endmodule

// [lsd_datapath.sv]
// lsd_datapath: logical, rotate, shift and swap unit with state sequencing
// assumes operands are fetched outside and valid in the cycle start is taken
`timescale 1ns/100ps

// Notes on behaviour
// - bitwise and, or, xor write back; byte pair 2 states binary, 1 source
// - word pair 3 bytes 3 states binary, 2 bytes 2 states source
// - word immediate 5 bytes 4 states binary, 4 bytes 3 states source
// - byte immediate 4 bytes 3 states binary, 3 bytes 2 states source
// - immediate into direct location 3 bytes 3 states in both modes
// - indirect into accumulator 2 states binary, 3 states source
// - byte via dword pointer 4 states binary, 3 source
// - byte via word pointer 3 states binary, 2 source
// - byte from long direct 5 bytes 3 states, 4 bytes 2 states
// - word from short direct 4 bytes 4 states, 3 bytes 3 states
// - reading a port adds 1 state, a special register adds 2
// - writing a port adds 2 states, a special register adds 3
// - external byte operand adds wait states plus 2
// - external word operand adds twice wait states plus 4
// - clear loads zero, invert flips bits 7 to 0 and leaves the upper byte zero; 1 byte 1 state
// - rotate left moves bit 7 into bit 0 in 1 state
// - rotate right moves bit 0 into bit 7 in 1 state
// - rotate left through carry: bit 7 to carry, carry to bit 0
// - rotate right through carry: bit 0 to carry, carry to bit 7
// - left shift inserts zero, msb to carry; 2 binary, 1 source states
// - arithmetic right shift keeps msb, bit 0 to carry
// - logical right shift loads zero msb, bit 0 to carry
module lsd_datapath #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// request
	input wire logic start,
	input wire lsd_pkg::lsd_op_e op,
	input wire lsd_pkg::lsd_form_e form,
	input wire logic word_size,
	input wire logic source_mode,
	input wire lsd_pkg::lsd_target_e target,
	input wire logic [3:0] wait_states,
	input wire logic [DATA_W-1:0] dest_opnd,
	input wire logic [DATA_W-1:0] src_opnd,
	input wire logic carry_in,
	// answer
	output logic busy,
	output logic done,
	output logic [DATA_W-1:0] result,
	output logic carry_flag,
	output logic carry_we,
	output logic [2:0] instr_bytes,
	output logic [7:0] instr_states
);
	typedef enum logic [2:0] {
		LSD_IDLE = 3'b001,
		LSD_RUN = 3'b010,
		LSD_DONE = 3'b100
	} lsd_state_e;

	typedef struct packed {
		lsd_state_e st;
		logic [7:0] cnt;
		logic [DATA_W-1:0] res;
		logic cy;
		logic cy_we;
		logic [2:0] nbytes;
		logic [7:0] nstates;
	} lsd_s;

	lsd_s q;
	lsd_s d;
	lsd_timing_if tif();
	logic [DATA_W-1:0] calc;
	logic calc_cy;
	logic calc_cy_we;
	logic msb;
	logic is_shift;
	logic wide;

	assign is_shift = op == lsd_pkg::LSD_SHIFT_LEFT_LOGICAL_OP ||
		op == lsd_pkg::LSD_SHIFT_RIGHT_ARITH_OP ||
		op == lsd_pkg::LSD_SHIFT_RIGHT_LOGICAL_OP;
	assign tif.form = form;
	assign tif.is_logic = op == lsd_pkg::LSD_AND_OP ||
		op == lsd_pkg::LSD_OR_OP || op == lsd_pkg::LSD_XOR_OP;
	assign tif.is_shift = is_shift;
	assign tif.is_swap = op == lsd_pkg::LSD_SWAP_OP;
	assign tif.source_mode = source_mode;
	assign tif.target = target;
	assign tif.wait_states = wait_states;
	// bitwise ops take their width from the form, shifts from word_size
	assign wide = tif.is_logic ? (form == lsd_pkg::LSD_F_WORD_WORD ||
		form == lsd_pkg::LSD_F_WORD_IMM || form == lsd_pkg::LSD_F_WORD_DIR ||
		form == lsd_pkg::LSD_F_WORD_LDIR) : word_size;

	lsd_timing u_timing (
		.t(tif)
	);

	// byte ops use the low byte; upper byte passes through as zero
	always_comb begin
		calc = lsd_pkg::LSD_ZERO16[DATA_W-1:0];
		calc_cy = carry_in;
		calc_cy_we = 1'b0;
		msb = word_size ? dest_opnd[DATA_W-1] : dest_opnd[7];
		case (op)
			lsd_pkg::LSD_AND_OP: calc = dest_opnd & src_opnd;
			lsd_pkg::LSD_OR_OP: calc = dest_opnd | src_opnd;
			lsd_pkg::LSD_XOR_OP: calc = dest_opnd ^ src_opnd;
			lsd_pkg::LSD_CLEAR_OP: calc = '0;
			lsd_pkg::LSD_INVERT_OP:
				calc = {{(DATA_W-8){1'b0}}, ~dest_opnd[7:0]};
			lsd_pkg::LSD_ROTATE_LEFT_OP:
				calc = {{(DATA_W-8){1'b0}}, dest_opnd[6:0], dest_opnd[7]};
			lsd_pkg::LSD_ROTATE_RIGHT_OP:
				calc = {{(DATA_W-8){1'b0}}, dest_opnd[0], dest_opnd[7:1]};
			lsd_pkg::LSD_ROTATE_LEFT_CARRY_OP: begin
				calc = {{(DATA_W-8){1'b0}}, dest_opnd[6:0], carry_in};
				calc_cy = dest_opnd[7];
				calc_cy_we = 1'b1;
			end
			lsd_pkg::LSD_ROTATE_RIGHT_CARRY_OP: begin
				calc = {{(DATA_W-8){1'b0}}, carry_in, dest_opnd[7:1]};
				calc_cy = dest_opnd[0];
				calc_cy_we = 1'b1;
			end
			lsd_pkg::LSD_SHIFT_LEFT_LOGICAL_OP: begin
				calc = {dest_opnd[DATA_W-2:0], 1'b0};
				calc_cy = msb;
				calc_cy_we = 1'b1;
			end
			lsd_pkg::LSD_SHIFT_RIGHT_ARITH_OP: begin
				calc = {1'b0, dest_opnd[DATA_W-1:1]};
				if (word_size)
					calc[DATA_W-1] = msb;
				else
					calc[7] = msb;
				calc_cy = dest_opnd[0];
				calc_cy_we = 1'b1;
			end
			lsd_pkg::LSD_SHIFT_RIGHT_LOGICAL_OP: begin
				calc = {1'b0, dest_opnd[DATA_W-1:1]};
				if (!word_size)
					calc[7] = 1'b0;
				calc_cy = dest_opnd[0];
				calc_cy_we = 1'b1;
			end
			lsd_pkg::LSD_SWAP_OP:
				calc = {{(DATA_W-8){1'b0}}, dest_opnd[3:0], dest_opnd[7:4]};
			default: calc = dest_opnd;
		endcase
		if (!wide)
			calc[DATA_W-1:8] = '0;
	end

	// result is latched at start, counter then burns the state budget
	always_comb begin
		d = q;
		d.cy_we = 1'b0;
		case (q.st)
			LSD_IDLE: begin
				if (start) begin
					d.res = calc;
					d.cy = calc_cy_we ? calc_cy : carry_in;
					d.nbytes = tif.bytes;
					d.nstates = tif.states;
					d.cnt = tif.states;
					d.st = (tif.states <= 8'h01) ? LSD_DONE : LSD_RUN;
					d.cy_we = 1'b0;
				end
			end
			LSD_RUN: begin
				d.cnt = q.cnt - 8'h01;
				if (q.cnt <= 8'h02)
					d.st = LSD_DONE;
			end
			LSD_DONE: begin
				d.st = LSD_IDLE;
			end
			default: d.st = LSD_IDLE;
		endcase
		if (q.st == LSD_IDLE && start)
			d.cy_we = calc_cy_we;
		else if (q.st != LSD_IDLE)
			d.cy_we = q.cy_we;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			q.st <= LSD_IDLE;
			q.cnt <= 8'h00;
			q.res <= '0;
			q.cy <= 1'b0;
			q.cy_we <= 1'b0;
			q.nbytes <= 3'h0;
			q.nstates <= 8'h00;
		end else begin
			q <= d;
		end
	end

	assign busy = q.st != LSD_IDLE;
	assign done = q.st == LSD_DONE;
	assign result = q.res;
	assign carry_flag = q.cy;
	assign carry_we = done & q.cy_we;
	assign instr_bytes = q.nbytes;
	assign instr_states = q.nstates;
endmodule

// [lsd_datapath_props.sv]
// lsd_datapath_props: concurrent checks on the datapath ports
// assumes one clock and the synchronous active-high reset
`timescale 1ns/100ps
module lsd_datapath_props #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// request
	input wire logic start,
	input wire lsd_pkg::lsd_op_e op,
	input wire lsd_pkg::lsd_form_e form,
	input wire logic word_size,
	input wire logic source_mode,
	input wire lsd_pkg::lsd_target_e target,
	input wire logic [3:0] wait_states,
	input wire logic [DATA_W-1:0] dest_opnd,
	input wire logic [DATA_W-1:0] src_opnd,
	input wire logic carry_in,
	// answer
	input wire logic busy,
	input wire logic done,
	input wire logic [DATA_W-1:0] result,
	input wire logic carry_flag,
	input wire logic carry_we,
	input wire logic [2:0] instr_bytes,
	input wire logic [7:0] instr_states
);
	logic take;
	assign take = start && !busy;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_clear_zero: assert property (
		take && op == lsd_pkg::LSD_CLEAR_OP |=> done && result == 16'h0000)
		else $error("clear result or timing wrong");
	a_invert_bits: assert property (
		take && op == lsd_pkg::LSD_INVERT_OP |=>
		done && result[7:0] == ~$past(dest_opnd[7:0]))
		else $error("invert result or timing wrong");
	a_rotate_left: assert property (
		take && op == lsd_pkg::LSD_ROTATE_LEFT_OP |=> done &&
		result[7:0] == {$past(dest_opnd[6:0]), $past(dest_opnd[7])})
		else $error("rotate left wrong");
	a_rotate_right: assert property (
		take && op == lsd_pkg::LSD_ROTATE_RIGHT_OP |=> done &&
		result[7:0] == {$past(dest_opnd[0]), $past(dest_opnd[7:1])})
		else $error("rotate right wrong");
	a_rotl_carry: assert property (
		take && op == lsd_pkg::LSD_ROTATE_LEFT_CARRY_OP |=> carry_we &&
		result[7:0] == {$past(dest_opnd[6:0]), $past(carry_in)} &&
		carry_flag == $past(dest_opnd[7]))
		else $error("rotate left through carry wrong");
	a_rotr_carry: assert property (
		take && op == lsd_pkg::LSD_ROTATE_RIGHT_CARRY_OP |=> carry_we &&
		result[7:0] == {$past(carry_in), $past(dest_opnd[7:1])} &&
		carry_flag == $past(dest_opnd[0]))
		else $error("rotate right through carry wrong");
	a_logic_carry: assert property (
		take && op inside {lsd_pkg::LSD_AND_OP, lsd_pkg::LSD_OR_OP,
		lsd_pkg::LSD_XOR_OP} |=> carry_flag == $past(carry_in) && !carry_we)
		else $error("bitwise op touched carry");
	a_word_pair: assert property (
		take && op == lsd_pkg::LSD_XOR_OP && !source_mode &&
		form == lsd_pkg::LSD_F_WORD_WORD |=> !done ##1 !done ##1 done)
		else $error("word pair binary timing wrong");
	a_shift_src: assert property (
		take && op == lsd_pkg::LSD_SHIFT_LEFT_LOGICAL_OP && source_mode
		|=> done && carry_we && result[0] == 1'b0)
		else $error("source mode left shift wrong");
	a_sra_msb: assert property (
		take && op == lsd_pkg::LSD_SHIFT_RIGHT_ARITH_OP && word_size |=>
		done == $past(source_mode) && result == {$past(dest_opnd[15]),
		$past(dest_opnd[15:1])} && carry_flag == $past(dest_opnd[0]))
		else $error("arithmetic right shift wrong");
endmodule
bind lsd_datapath lsd_datapath_props #(.DATA_W(DATA_W)) u_props (
	.clock(clock), .sys_rst(sys_rst), .start(start), .op(op), .form(form),
	.word_size(word_size), .source_mode(source_mode), .target(target),
	.wait_states(wait_states), .dest_opnd(dest_opnd), .src_opnd(src_opnd),
	.carry_in(carry_in), .busy(busy), .done(done), .result(result),
	.carry_flag(carry_flag), .carry_we(carry_we),
	.instr_bytes(instr_bytes), .instr_states(instr_states));

// [lsd_datapath_bench.sv]
// lsd_datapath_bench: random and corner runs of every op and form
// assumes the datapath alone, driven at the falling clock edge
`timescale 1ns/100ps
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module lsd_datapath_bench;
	logic clock = 1'b0, sys_rst = 1'b1, start = 1'b0;
	lsd_pkg::lsd_op_e op = lsd_pkg::LSD_AND_OP;
	lsd_pkg::lsd_form_e form = lsd_pkg::LSD_F_ACC_REG;
	lsd_pkg::lsd_target_e target = lsd_pkg::LSD_T_RAM;
	logic word_size = 1'b0, source_mode = 1'b0, carry_in = 1'b0;
	logic [3:0] wait_states = 4'h0;
	logic [15:0] dest_opnd = 16'h0000, src_opnd = 16'h0000, result;
	logic busy, done, carry_flag, carry_we;
	logic [2:0] instr_bytes;
	logic [7:0] instr_states;
	int n_mismatch = 0, n_compared = 0, seed = 33154, cycles = 0;
	// bytes and states: binary bytes, binary, source bytes, source
	logic [15:0] tbl [16] = '{16'h1122, 16'h2121, 16'h1223, 16'h2121,
		16'h2222, 16'h3333, 16'h3221, 16'h3322, 16'h4332, 16'h5443,
		16'h4332, 16'h4433, 16'h5342, 16'h5443, 16'h4332, 16'h4433};

	lsd_datapath #(.DATA_W(16)) DUT (.clock(clock), .sys_rst(sys_rst),
		.start(start), .op(op), .form(form), .word_size(word_size),
		.source_mode(source_mode), .target(target),
		.wait_states(wait_states), .dest_opnd(dest_opnd),
		.src_opnd(src_opnd), .carry_in(carry_in), .busy(busy),
		.done(done), .result(result), .carry_flag(carry_flag),
		.carry_we(carry_we), .instr_bytes(instr_bytes),
		.instr_states(instr_states));

	always #5 clock = ~clock;

	function automatic logic [7:0] exp_states(logic [3:0] o, f, logic sm,
		logic [1:0] tg, logic [3:0] n);
		logic [7:0] s;
		if (o > 4'h2)
			return (o == 4'hC) ? 8'h02 : (o > 4'h8 && !sm) ? 8'h02 : 8'h01;
		s = {4'h0, sm ? tbl[f][3:0] : tbl[f][11:8]};
		if (f == 4'h1 || f == 4'hA)
			s = s + ((tg == 2'h1) ? 8'h01 : (tg == 2'h2) ? 8'h02 : 8'h00);
		if (f == 4'h4 || f == 4'h5)
			s = s + ((tg == 2'h1) ? 8'h02 : (tg == 2'h2) ? 8'h03 : 8'h00);
		if (tg == 2'h3 && (f == 4'hC || f == 4'hE || f == 4'hF))
			s = s + {4'h0, n} + 8'h02;
		if (tg == 2'h3 && f == 4'hD)
			s = s + 8'h02 * ({4'h0, n} + 8'h02);
		return s;
	endfunction

	function automatic logic [2:0] exp_bytes(logic [3:0] o, f, logic sm);
		if (o > 4'h2)
			return (o > 4'h8 && o < 4'hC) ? (sm ? 3'h2 : 3'h3) : 3'h1;
		return sm ? tbl[f][6:4] : tbl[f][14:12];
	endfunction

	// carry above result
	function automatic logic [16:0] exp_res(logic [3:0] o, f, logic ws,
		logic [15:0] d, s, logic c);
		logic [16:0] r;
		case (o)
			4'h0: r = {c, d & s};
			4'h1: r = {c, d | s};
			4'h2: r = {c, d ^ s};
			4'h3: r = {c, 16'h0000};
			4'h4: r = {c, 8'h00, ~d[7:0]};
			4'h5: r = {c, 8'h00, d[6:0], d[7]};
			4'h6: r = {c, 8'h00, d[0], d[7:1]};
			4'h7: r = {d[7], 8'h00, d[6:0], c};
			4'h8: r = {d[0], 8'h00, c, d[7:1]};
			4'h9: r = ws ? {d, 1'b0} : {d[7], 8'h00, d[6:0], 1'b0};
			4'hA: r = ws ? {d[0], d[15], d[15:1]} : {d[0], 8'h00, d[7], d[7:1]};
			4'hB: r = ws ? {d[0], 1'b0, d[15:1]} : {d[0], 9'h000, d[7:1]};
			default: r = {c, 8'h00, d[3:0], d[7:4]};
		endcase
		// byte forms keep the upper byte clear
		if (o < 4'h3 && !(f == 4'h7 || f == 4'h9 || f == 4'hB || f == 4'hD))
			r[15:8] = 8'h00;
		return r;
	endfunction

	task automatic run_op(input logic [3:0] o, f, input logic ws, sm,
		input logic [1:0] tg, input logic [3:0] n, input logic hold);
		logic [16:0] e;
		int k;
		@(negedge clock);
		`CMP(busy, 1'b0)
		op = lsd_pkg::lsd_op_e'(o);
		form = lsd_pkg::lsd_form_e'(f);
		target = lsd_pkg::lsd_target_e'(tg);
		{word_size, source_mode, wait_states} = {ws, sm, n};
		dest_opnd = 16'($random(seed));
		src_opnd = 16'($random(seed));
		carry_in = 1'($random(seed));
		start = 1'b1;
		e = exp_res(o, f, ws, dest_opnd, src_opnd, carry_in);
		k = 0;
		// a held start must be refused and late operand changes ignored
		do begin
			@(negedge clock);
			k++;
			if (hold)
				src_opnd = ~src_opnd;
			else
				start = 1'b0;
		end while (done !== 1'b1 && k < 64);
		start = 1'b0;
		`CMP(k, exp_states(o, f, sm, tg, n))
		`CMP(instr_states, exp_states(o, f, sm, tg, n))
		`CMP(instr_bytes, exp_bytes(o, f, sm))
		`CMP(result, e[15:0])
		`CMP(carry_flag, e[16])
		`CMP(carry_we, (o > 4'h6 && o < 4'hC))
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		@(negedge clock) sys_rst = 1'b0;
		for (int o = 0; o < 3; o++)
			for (int f = 0; f < 16; f++)
				for (int m = 0; m < 2; m++)
					run_op(4'(o), 4'(f), 1'b0, 1'(m), 2'($random(seed)),
						4'($random(seed)), 1'b0);
		$display("test forms ended");
		for (int o = 3; o < 13; o++)
			for (int m = 0; m < 4; m++)
				run_op(4'(o), 4'h0, m[1], m[0], 2'h0, 4'h0, 1'b0);
		$display("test accumulator and shifts ended");
		for (int t = 0; t < 4; t++) begin
			run_op(4'h1, 4'hD, 1'b0, 1'b1, 2'(t), 4'hF, 1'b0);
			run_op(4'h2, 4'h5, 1'b0, 1'b0, 2'(t), 4'h0, 1'b0);
			run_op(4'h0, 4'hA, 1'b0, 1'b1, 2'(t), 4'h0, 1'b0);
		end
		run_op(4'h2, 4'h7, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1);
		run_op(4'h7, 4'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1);
		$display("test targets and refusal ended");
		repeat (200)
			run_op(4'({$random(seed)} % 13), 4'($random(seed)),
				1'($random(seed)), 1'($random(seed)), 2'($random(seed)),
				4'($random(seed)), 1'b0);
		$display("test random ended");
		wrap_up();
	end
endmodule
